// file: dv/ppg_blender_model.sv
// Stand-in for the blender upstream and the colour stage downstream
`timescale 1ns/1ns
`default_nettype none
module ppg_blender_model import ppg_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire ppg_pix_in_type pix_next,
  output ppg_pix_in_type pix_in,
  input wire ppg_pix_out_type pix_out,
  output ppg_pix_out_type pix_seen
);
  // One pixel launched and one taken on every clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_in <= '0;
      pix_seen <= '0;
    end else begin
      pix_in <= pix_next;
      pix_seen <= pix_out;
    end
  end
endmodule
`default_nettype wire

// file: dv/ppg_gamma_test.sv
// Self-checking bench of the palette and gamma unit
`timescale 1ns/1ns
`default_nettype none
module ppg_gamma_test import ppg_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ppg_vga_wr_type vga_wr = '0;
  ppg_pix_in_type pix_next = '0;
  ppg_pix_in_type pix_in;
  ppg_pix_out_type pix_out;
  ppg_pix_out_type pix_seen;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [29:0] prec [1024];
  logic [29:0] sf [18];
  logic [23:0] leg [256];
  logic [18:0] gp1 [3];
  logic [18:0] gb1 [3];
  logic [18:0] gb3 [3];
  logic [27:0] pts [4] = '{ONE_IN, 28'h2000000, THREE_IN, 28'h5000000};

  ppg_gamma DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .vga_wr(vga_wr),
    .pix_in(pix_in), .pix_out(pix_out));
  ppg_blender_model partner (.pclk(pclk), .presetn(presetn),
    .pix_next(pix_next), .pix_in(pix_in), .pix_out(pix_out),
    .pix_seen(pix_seen));

  initial forever #50 pclk = ~pclk;

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk(e === 1'b0, "write refused");
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
      input logic ex_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r === x && e === ex_err, "register read");
  endtask

  function automatic logic [15:0] ent(input int w, input int c);
    return {prec[w + 1][10 * c +: 10], prec[w][10 * c +: 6]};
  endfunction

  function automatic logic [19:0] ex(input logic [1:0] m, input int c,
      input logic [27:0] x);
    logic [27:0] g;
    logic [19:0] p;
    logic [19:0] r;
    int k;
    g = x[27] ? -x : x;
    if (g > MAG_MAX) g = MAG_MAX;
    if (m == CODE_LEGACY) begin
      k = x[27] ? 0 : (x >= ONE_IN ? 255 : int'(x[23:16]));
      return {4'h0, leg[k][8 * c +: 8], 8'h0};
    end
    p = {1'b0, gp1[c]};
    if (m == CODE_DIRECT) p = {4'h0, prec[1023][10 * c +: 10], 6'h0};
    if (g == ONE_IN) r = p;
    else if (g == 28'h2000000) r = (p + gb1[c]) >> 1;
    else if (g == THREE_IN) r = {1'b0, gb1[c]};
    else if (g == 28'h5000000) r = (gb1[c] + gb3[c]) >> 1;
    else if (g > THREE_IN) r = {1'b0, gb1[c]};
    else if (m == CODE_DIRECT) r = {4'h0, prec[g[23:14]][10 * c +: 10], 6'h0};
    else if (m == CODE_INTERP) r = {4'h0, ent(2 * g[23:15], c)};
    else if (g < SF_LIMIT)
      r = {4'h0, sf[2 * g[8:6] + 1][10 * c +: 10], sf[2 * g[8:6]][10 * c +: 6]};
    else if (g < FINE_LIMIT) r = {4'h0, ent(2 * g[16:9] - 2, c)};
    else r = {4'h0, ent(512 + 2 * g[23:16], c)};
    return x[27] ? -r : r;
  endfunction

  function automatic logic [27:0] pick(input logic [1:0] m);
    logic [27:0] x;
    case (m)
      CODE_LEGACY: x = 28'($urandom % 256) << 16;
      CODE_DIRECT: x = 28'($urandom % 1024) << 14;
      CODE_INTERP: x = 28'($urandom % 512) << 15;
      default: begin
        case ($urandom % 3)
          0: x = 28'($urandom % 8) << 6;
          1: x = 28'($urandom % 255 + 1) << 9;
          default: x = 28'($urandom % 254 + 2) << 16;
        endcase
      end
    endcase
    if ($urandom % 2) x = -x;
    return x;
  endfunction

  task automatic px(input logic [1:0] m, input logic en,
      input logic [2:0][27:0] x);
    ppg_pix_out_type want;
    want.valid = 1'b1;
    for (int c = 0; c < 3; c++) want.comp[c] = en ? ex(m, c, x[c]) : x[c][27:8];
    @(posedge pclk);
    pix_next <= {1'b1, en, x};
    repeat (3) @(posedge pclk);
    #1 chk(pix_seen === want, "pixel result");
  endtask

  task automatic run(input logic [1:0] m);
    wr(CTRL_OFF, {30'h0, m});
    for (int i = 0; i < 16; i++) px(m, 1'b1, {pick(m), pick(m), pick(m)});
    px(m, 1'b0, {28'($urandom), 28'($urandom), 28'($urandom)});
    if (m != CODE_LEGACY) begin
      foreach (pts[i]) px(m, 1'b1, {pts[i], -pts[i], pts[i]});
    end
  endtask

  initial begin
    logic [31:0] w;
    logic [15:0] v;
    w = $urandom(32'h07ea);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(CTRL_OFF, 32'h0, 1'b0);
    rd(12'h0fc, 32'h0, 1'b1);
    rd(12'h002, 32'h0, 1'b1);
    for (int m = 0; m < 4; m++) begin
      wr(CTRL_OFF, m);
      rd(CTRL_OFF, m, 1'b0);
    end
    wr(CTRL_OFF, 32'h0);
    wr(LEG_IDX_OFF, 32'h0);
    for (int i = 0; i < 256; i++) begin
      leg[i] = 24'($urandom);
      wr(LEG_DATA_OFF, {8'h0, leg[i]});
    end
    wr(LEG_IDX_OFF, 32'h7);
    rd(LEG_DATA_OFF, {8'h0, leg[7]}, 1'b0);
    rd(LEG_DATA_OFF, {8'h0, leg[8]}, 1'b0);
    for (int i = 0; i < 2; i++) begin
      w = $urandom;
      @(posedge pclk);
      vga_wr <= {1'b1, i[0], 8'(i + 3), w[23:0]};
      @(posedge pclk);
      vga_wr <= '0;
      leg[i + 3] = i ? w[23:0] : {w[21:16], 2'b0, w[13:8], 2'b0, w[5:0], 2'b0};
    end
    px(CODE_LEGACY, 1'b1, {28'h0040000, 28'h0030000, 28'h4000000});
    run(CODE_LEGACY);
    wr(PREC_IDX_OFF, 32'h0);
    for (int k = 0; k < 1024; k++) begin
      prec[k] = {10'(k), 10'(k >> 1), 10'(k >> 2)};
      wr(PREC_DATA_OFF, {2'b0, prec[k]});
    end
    for (int c = 0; c < 3; c++) begin
      gp1[c] = 19'h10000 + 19'(2 * c);
      gb1[c] = 19'h28000 + 19'(4 * c);
      gb3[c] = 19'h50000 + 19'(8 * c);
      wr(12'h020 + 12'(4 * c), {13'h0, gp1[c]});
      wr(12'h030 + 12'(4 * c), {13'h0, gb1[c]});
      wr(12'h040 + 12'(4 * c), {13'h0, gb3[c]});
      rd(12'h030 + 12'(4 * c), {13'h0, gb1[c]}, 1'b0);
    end
    run(CODE_DIRECT);
    wr(PREC_IDX_OFF, 32'h0);
    for (int k = 0; k < 512; k++) begin
      for (int c = 0; c < 3; c++) begin
        // first point zero, rising curve, fits 16 bits
        v = (k == 0) ? 16'h0 : 16'(k * 128 + $urandom % 128);
        prec[2 * k][10 * c +: 10] = {4'h0, v[5:0]};
        prec[2 * k + 1][10 * c +: 10] = v[15:6];
      end
      wr(PREC_DATA_OFF, {2'b0, prec[2 * k]});
      wr(PREC_DATA_OFF, {2'b0, prec[2 * k + 1]});
    end
    wr(PREC_IDX_OFF, 32'h5);
    rd(PREC_DATA_OFF, {2'b0, prec[5]}, 1'b0);
    rd(PREC_DATA_OFF, {2'b0, prec[6]}, 1'b0);
    run(CODE_INTERP);
    wr(SF_IDX_OFF, 32'h0);
    for (int j = 0; j < 9; j++) begin
      for (int c = 0; c < 3; c++) begin
        v = 16'(j * (1000 + c));
        sf[2 * j][10 * c +: 10] = {4'h0, v[5:0]};
        sf[2 * j + 1][10 * c +: 10] = v[15:6];
      end
      wr(SF_DATA_OFF, {2'b0, sf[2 * j]});
      wr(SF_DATA_OFF, {2'b0, sf[2 * j + 1]});
    end
    wr(SF_DATA_OFF, 32'h3fffffff);
    wr(SF_IDX_OFF, 32'h12);
    rd(SF_DATA_OFF, 32'h0, 1'b0);
    wr(SF_IDX_OFF, 32'h1);
    rd(SF_DATA_OFF, {2'b0, sf[1]}, 1'b0);
    run(CODE_MULTI);
    for (int c = 0; c < 3; c++) begin
      gb3[c] = gb1[c];
      wr(12'h040 + 12'(4 * c), {13'h0, gb3[c]});
    end
    px(CODE_MULTI, 1'b1, {28'h7ffffff, 28'h8000000, 28'h6ffffff});
    wr(CTRL_OFF, {30'h0, CODE_DIRECT});
    px(CODE_DIRECT, 1'b1, {28'h9000001, 28'h7000000, 28'h8000000});
    wrap_up();
  end
endmodule
`default_nettype wire

// file: rtl/ppg_gamma.sv
// Pipe palette and gamma unit with APB register access
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module ppg_gamma import ppg_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ppg_vga_wr_type vga_wr,
  input wire ppg_pix_in_type pix_in,
  output ppg_pix_out_type pix_out
);

  typedef struct packed {
    ppg_mode_type mode;
    logic [7:0] leg_idx;
    logic [9:0] prec_idx;
    logic [4:0] sf_idx;
    logic [255:0][2:0][7:0] leg;
    logic [1023:0][2:0][9:0] prec;
    logic [17:0][2:0][9:0] sf;
    logic [2:0][16:0] gp1;
    logic [2:0][18:0] gpb1;
    logic [2:0][18:0] gpb3;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    ppg_pix_out_type pix;
  } ppg_state_type;

  ppg_state_type s_q;
  ppg_state_type s_d;

  logic [2:0] neg_w;
  logic [2:0][27:0] mag_w;
  logic [2:0][18:0] p0_w;
  logic [2:0][18:0] p1_w;
  logic [2:0][15:0] fr_w;
  logic [2:0][19:0] y_w;
  logic setup_w;
  logic acc_w;

  // every code maps to one mode
  function automatic ppg_mode_type mode_of(input logic [1:0] code);
    case (code)
      CODE_DIRECT: mode_of = MODE_DIRECT;
      CODE_INTERP: mode_of = MODE_INTERP;
      CODE_MULTI: mode_of = MODE_MULTI;
      default: mode_of = MODE_LEGACY;
    endcase
  endfunction

  function automatic logic [1:0] mode_code(input ppg_mode_type m);
    case (m)
      MODE_DIRECT: mode_code = CODE_DIRECT;
      MODE_INTERP: mode_code = CODE_INTERP;
      MODE_MULTI: mode_code = CODE_MULTI;
      default: mode_code = CODE_LEGACY;
    endcase
  endfunction

  // upper bits odd word, lower bits even word
  function automatic logic [18:0] pe(input logic [9:0] ev,
                                     input logic [1:0] c);
    pe = {3'b000, s_q.prec[ev | 10'h001][c], s_q.prec[ev][c][5:0]};
  endfunction

  function automatic logic [18:0] se(input logic [4:0] ev,
                                     input logic [1:0] c);
    se = {3'b000, s_q.sf[ev | 5'h01][c], s_q.sf[ev][c][5:0]};
  endfunction

  function automatic logic [32:0] rd(input logic [11:0] a);
    rd = {1'b0, 32'h0};
    case (a)
      CTRL_OFF: rd[1:0] = mode_code(s_q.mode);
      LEG_IDX_OFF: rd[7:0] = s_q.leg_idx;
      LEG_DATA_OFF: rd[23:0] = s_q.leg[s_q.leg_idx];
      PREC_IDX_OFF: rd[9:0] = s_q.prec_idx;
      PREC_DATA_OFF: rd[29:0] = s_q.prec[s_q.prec_idx];
      SF_IDX_OFF: rd[4:0] = s_q.sf_idx;
      SF_DATA_OFF: begin
        if (s_q.sf_idx < SF_WORDS) begin
          rd[29:0] = s_q.sf[s_q.sf_idx];
        end
      end
      default: begin
        if (a[1:0] != 2'b00 || a[3:2] == 2'b11) begin
          rd[32] = 1'b1;
        end else if (a[11:4] == GP1_BLK) begin
          rd[16:0] = s_q.gp1[a[3:2]];
        end else if (a[11:4] == GPB1_BLK) begin
          rd[18:0] = s_q.gpb1[a[3:2]];
        end else if (a[11:4] == GPB3_BLK) begin
          rd[18:0] = s_q.gpb3[a[3:2]];
        end else begin
          rd[32] = 1'b1;
        end
      end
    endcase
  endfunction

  // Curve point selection per colour
  always_comb begin
    logic [27:0] raw;
    logic [27:0] d;
    logic [8:0] i9;
    logic [7:0] i8;
    logic [2:0] i3;
    raw = '0;
    d = '0;
    i9 = '0;
    i8 = '0;
    i3 = '0;
    for (int c = 0; c < 3; c++) begin
      neg_w[c] = pix_in.comp[c][27];
      raw = neg_w[c] ? 28'(-pix_in.comp[c]) : pix_in.comp[c];
      mag_w[c] = (raw > MAG_MAX) ? MAG_MAX : raw;
      p0_w[c] = '0;
      p1_w[c] = '0;
      fr_w[c] = '0;
      case (s_q.mode)
        MODE_LEGACY: begin
          i8 = neg_w[c] ? 8'h00 : ((raw >= ONE_IN) ? 8'hff : raw[23:16]);
          p0_w[c] = {3'b000, s_q.leg[i8][c], 8'h00};
          p1_w[c] = p0_w[c];
        end
        MODE_DIRECT: begin
          p0_w[c] = {3'b000, s_q.prec[mag_w[c][23:14]][c], 6'h00};
          p1_w[c] = p0_w[c];
        end
        MODE_INTERP: begin
          i9 = mag_w[c][23:15];
          p0_w[c] = pe({i9, 1'b0}, 2'(c));
          p1_w[c] = (i9 == INTERP_LAST) ? {2'b00, s_q.gp1[c]}
                                        : pe({9'(i9 + 9'h001), 1'b0}, 2'(c));
          fr_w[c] = {mag_w[c][14:0], 1'b0};
        end
        MODE_MULTI: begin
          if (mag_w[c] < SF_LIMIT) begin
            i3 = mag_w[c][8:6];
            p0_w[c] = se({1'b0, i3, 1'b0}, 2'(c));
            p1_w[c] = se({({1'b0, i3} + 4'h1), 1'b0}, 2'(c));
            fr_w[c] = {mag_w[c][5:0], 10'h000};
          end else if (mag_w[c] < FINE_LIMIT) begin
            i8 = mag_w[c][16:9];
            p0_w[c] = (i8 == 8'h00) ? 19'h00000
                                    : pe({1'b0, 8'(i8 - 8'h01), 1'b0}, 2'(c));
            p1_w[c] = pe({1'b0, i8, 1'b0}, 2'(c));
            fr_w[c] = {mag_w[c][8:0], 7'h00};
          end else begin
            i8 = mag_w[c][23:16];
            p0_w[c] = pe({1'b1, i8, 1'b0}, 2'(c));
            p1_w[c] = (i8 == COARSE_LAST) ? {2'b00, s_q.gp1[c]}
                                          : pe({1'b1, 8'(i8 + 8'h01), 1'b0},
                                               2'(c));
            fr_w[c] = mag_w[c][15:0];
          end
        end
        default: begin
          p0_w[c] = '0;
        end
      endcase
      if (s_q.mode != MODE_LEGACY && mag_w[c] >= ONE_IN) begin
        if (mag_w[c] < THREE_IN) begin
          d = mag_w[c] - ONE_IN;
          p0_w[c] = (s_q.mode == MODE_DIRECT)
                    ? {3'b000, s_q.prec[PREC_LAST][c], 6'h00}
                    : {2'b00, s_q.gp1[c]};
          p1_w[c] = s_q.gpb1[c];
          fr_w[c] = d[24:9];
        end else begin
          d = mag_w[c] - THREE_IN;
          p0_w[c] = s_q.gpb1[c];
          p1_w[c] = s_q.gpb3[c];
          fr_w[c] = d[25:10];
        end
      end
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_lerp
    ppg_lerp u_lerp (
      .p0(p0_w[g]),
      .p1(p1_w[g]),
      .frac(fr_w[g]),
      .y(y_w[g])
    );
  end

  assign setup_w = psel & ~penable;
  assign acc_w = psel & penable & s_q.pready;

  always_comb begin
    s_d = s_q;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    if (setup_w) begin
      s_d.pready = 1'b1;
      {s_d.pslverr, s_d.prdata} = rd(paddr);
    end
    if (acc_w && !s_q.pslverr) begin
      case (paddr)
        CTRL_OFF: begin
          if (pwrite) begin
            s_d.mode = mode_of(pwdata[1:0]);
          end
        end
        LEG_IDX_OFF: begin
          if (pwrite) begin
            s_d.leg_idx = pwdata[7:0];
          end
        end
        LEG_DATA_OFF: begin
          if (pwrite) begin
            s_d.leg[s_q.leg_idx] = pwdata[23:0];
          end
          s_d.leg_idx = s_q.leg_idx + 8'h01;
        end
        PREC_IDX_OFF: begin
          if (pwrite) begin
            s_d.prec_idx = pwdata[9:0];
          end
        end
        PREC_DATA_OFF: begin
          if (pwrite) begin
            s_d.prec[s_q.prec_idx] = pwdata[29:0];
          end
          s_d.prec_idx = s_q.prec_idx + 10'h001;
        end
        SF_IDX_OFF: begin
          if (pwrite) begin
            s_d.sf_idx = pwdata[4:0];
          end
        end
        SF_DATA_OFF: begin
          if (pwrite && s_q.sf_idx < SF_WORDS) begin
            s_d.sf[s_q.sf_idx] = pwdata[29:0];
          end
          s_d.sf_idx = s_q.sf_idx + 5'h01;
        end
        default: begin
          if (pwrite && paddr[11:4] == GP1_BLK) begin
            s_d.gp1[paddr[3:2]] = pwdata[16:0];
          end else if (pwrite && paddr[11:4] == GPB1_BLK) begin
            s_d.gpb1[paddr[3:2]] = pwdata[18:0];
          end else if (pwrite && paddr[11:4] == GPB3_BLK) begin
            s_d.gpb3[paddr[3:2]] = pwdata[18:0];
          end
        end
      endcase
    end
    // VGA path, six-bit colours shifted up
    if (vga_wr.en) begin
      for (int c = 0; c < 3; c++) begin
        s_d.leg[vga_wr.index][c] = vga_wr.wide ? vga_wr.rgb[c]
                                               : {vga_wr.rgb[c][5:0], 2'b00};
      end
    end
    s_d.pix.valid = pix_in.valid;
    for (int c = 0; c < 3; c++) begin
      if (!pix_in.gamma_en) begin
        // plane without gamma bypasses the palette
        s_d.pix.comp[c] = pix_in.comp[c][27:8];
      end else if (s_q.mode != MODE_LEGACY && neg_w[c]) begin
        s_d.pix.comp[c] = 20'(-y_w[c]);
      end else begin
        s_d.pix.comp[c] = y_w[c];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.mode <= MODE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign pix_out = s_q.pix;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_ctrl_write;
    acc_w && pwrite && paddr == CTRL_OFF && !pslverr;
  endsequence

  a_apb_answer: assert property (s_setup |=> pready ##1 !pready)
    else $error("APB answer not one access cycle");

  a_bypass_pass: assert property (pix_in.valid && !pix_in.gamma_en |=>
      pix_out.valid && pix_out.comp[0] == $past(pix_in.comp[0][27:8]))
    else $error("Bypassed pixel altered");

  a_mode_onehot: assert property ($onehot(s_q.mode))
    else $error("Mode not one-hot");

  a_mode_write: assert property (s_ctrl_write |=>
      s_q.mode == mode_of($past(pwdata[1:0])) ##1 $stable(s_q.mode))
    else $error("Mode field not taken");

  a_legacy_clamp: assert property (s_q.mode == MODE_LEGACY &&
      pix_in.gamma_en && neg_w[0] && !vga_wr.en |=>
      pix_out.comp[0] == {4'h0, s_q.leg[0][0], 8'h00})
    else $error("Legacy negative input not clamped");

  a_vga_narrow: assert property (vga_wr.en && !vga_wr.wide |=>
      s_q.leg[$past(vga_wr.index)][0] == {$past(vga_wr.rgb[0][5:0]), 2'b00})
    else $error("Six-bit VGA write wrong");

  a_direct_lookup: assert property (s_q.mode == MODE_DIRECT &&
      pix_in.gamma_en && !neg_w[0] && mag_w[0] < ONE_IN |->
      y_w[0] == {4'h0, s_q.prec[mag_w[0][23:14]][0], 6'h00})
    else $error("Direct lookup wrong");

  a_clamp_range: assert property (pix_in.comp[0][27] ||
      pix_in.comp[0] < MAG_MAX || mag_w[0] == MAG_MAX)
    else $error("Magnitude not clamped");

  a_mirror_sign: assert property (s_q.mode != MODE_LEGACY &&
      pix_in.gamma_en && neg_w[0] && $stable(s_q.mode) |=>
      pix_out.comp[0] == 20'(-$past(y_w[0])))
    else $error("Negative input not mirrored");

  a_prec_autoinc: assert property (acc_w && !pslverr &&
      paddr == PREC_DATA_OFF |=> s_q.prec_idx == $past(s_q.prec_idx) + 10'h001)
    else $error("Index did not advance");

  a_gp_one_point: assert property (s_q.mode == MODE_INTERP &&
      mag_w[0] == ONE_IN |-> y_w[0] == {3'b000, s_q.gp1[0]})
    else $error("Point at one not used");

endmodule
`default_nettype wire

// file: rtl/ppg_lerp.sv
// Linear interpolation between two curve points
`timescale 1ns/1ns
`default_nettype none
module ppg_lerp import ppg_pkg::*; (
  input wire logic [18:0] p0,
  input wire logic [18:0] p1,
  input wire logic [15:0] frac,
  output logic signed [19:0] y
);
  logic signed [19:0] diff;
  logic signed [36:0] prod;
  logic signed [20:0] sum;

  always_comb begin
    diff = $signed({1'b0, p1}) - $signed({1'b0, p0});
    prod = diff * $signed({1'b0, frac});
    sum = $signed({2'b00, p0}) + $signed(prod[36:16]);
    y = sum[19:0];
  end
endmodule
`default_nettype wire

// file: rtl/ppg_pkg.sv
// Shared constants and carrier types of the pipe palette and gamma unit
package ppg_pkg;

  // Register byte offsets on the APB
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] LEG_IDX_OFF = 12'h004;
  localparam logic [11:0] LEG_DATA_OFF = 12'h008;
  localparam logic [11:0] PREC_IDX_OFF = 12'h00c;
  localparam logic [11:0] PREC_DATA_OFF = 12'h010;
  localparam logic [11:0] SF_IDX_OFF = 12'h014;
  localparam logic [11:0] SF_DATA_OFF = 12'h018;
  // Point registers: block in addr[11:4], colour in addr[3:2]
  localparam logic [7:0] GP1_BLK = 8'h02;
  localparam logic [7:0] GPB1_BLK = 8'h03;
  localparam logic [7:0] GPB3_BLK = 8'h04;

  // Mode field encoding in the control register
  localparam logic [1:0] CODE_LEGACY = 2'h0;
  localparam logic [1:0] CODE_DIRECT = 2'h1;
  localparam logic [1:0] CODE_INTERP = 2'h2;
  localparam logic [1:0] CODE_MULTI = 2'h3;

  // Table sizes
  localparam logic [9:0] PREC_LAST = 10'h3ff;
  localparam logic [4:0] SF_WORDS = 5'h12;
  localparam logic [8:0] INTERP_LAST = 9'h1ff;
  localparam logic [7:0] COARSE_LAST = 8'hff;

  // Input magnitudes, unsigned 3.24
  localparam logic [27:0] ONE_IN = 28'h1000000;
  localparam logic [27:0] THREE_IN = 28'h3000000;
  localparam logic [27:0] MAG_MAX = 28'h6ffffff;
  localparam logic [27:0] SF_LIMIT = 28'h0000200;
  localparam logic [27:0] FINE_LIMIT = 28'h0020000;

  typedef enum logic [3:0] {
    MODE_LEGACY = 4'b0001,
    MODE_DIRECT = 4'b0010,
    MODE_INTERP = 4'b0100,
    MODE_MULTI = 4'b1000
  } ppg_mode_type;

  localparam ppg_mode_type MODE_RST = MODE_LEGACY;

  // Blended pixel in: signed 3.24 per colour, [2]=R [1]=G [0]=B
  typedef struct packed {
    logic valid;
    logic gamma_en;
    logic [2:0][27:0] comp;
  } ppg_pix_in_type;

  // Corrected pixel out: signed 3.16 per colour
  typedef struct packed {
    logic valid;
    logic [2:0][19:0] comp;
  } ppg_pix_out_type;

  // Palette write from the VGA I/O side
  typedef struct packed {
    logic en;
    logic wide;
    logic [7:0] index;
    logic [2:0][7:0] rgb;
  } ppg_vga_wr_type;

endpackage
